// file: rtl/osc_mode_pkg.sv
// Constants and types for the dual clock mode controller
package osc_mode_pkg;
	// Register index as printed; byte address is four times it
	localparam logic [9:0] OSC_CTRL_INDEX = 10'h0CA;
	localparam logic [11:0] OSC_CTRL_ADDR = {OSC_CTRL_INDEX, 2'h0};
	// Field positions inside the control byte
	localparam int HIGH_OSC_STOP_POS = 1;
	localparam int SLOW_CLOCK_SELECT_POS = 2;
	localparam int CPU_MODE_LSB_POS = 3;
	localparam int PRESCALE_SELECT_POS = 5;
	localparam int WATCHDOG_CLEAR_POS = 6;
	localparam int WATCHDOG_CLOCK_POS = 7;
	// Value after reset of the whole control byte
	localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
	// Operating mode codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_GREEN = 2'h2;
	// Instruction rate dividers, counted in oscillator edges
	localparam logic [3:0] DIV_EXT_HIGH = 4'h3;
	localparam logic [3:0] DIV_INT_HIGH = 4'hF;
	localparam logic [3:0] DIV_LOW = 4'h3;
	// Watchdog prescale taps and slow RC divider
	localparam int PRESCALE_LONG_BIT = 13;
	localparam int PRESCALE_SHORT_BIT = 7;
	localparam int SLOW_RC_DIV_BIT = 8;
	localparam logic [13:0] PRESCALE_RESET = 14'h0000;
	localparam logic [3:0] WD_COUNT_RESET = 4'h0;
	// Oscillator edges to wait after a wake from sleep
	localparam logic [11:0] WAKE_EDGES = 12'h800;
	// Control byte fields, bit 0 kept as a spare that reads zero
	typedef struct packed {
		logic watchdog_clock_select;
		logic watchdog_clear;
		logic watchdog_prescale_select;
		logic [1:0] cpu_operating_mode;
		logic slow_clock_select;
		logic high_osc_stop;
		logic spare;
	} osc_ctrl_t;
	// Controller phases
	typedef enum logic [2:0] {
		PH_START,
		PH_RUN,
		PH_SLEEP,
		PH_WAKE,
		PH_GREEN
	} phase_t;
endpackage : osc_mode_pkg

// file: rtl/dual_clock_mode_control.sv
// Dual clock mode controller with its oscillator control register on Wishbone
// Summary of operation
// - External high clock divided by 4
// - Internal fast RC divided by 16
// - Slow mode: low clock divided by 4
// - Control byte at 0CAH, resets to zero
// - Stop bit halts only the high oscillator, external or internal RC
// - Clock mode bit selects low clock
// - Mode field: normal, sleep, green, reserved
// - Prescale bit picks 2^14 or 2^8
// - Writing one clears watchdog counter
// - Watchdog clock select, forced by option
// - Slow RC watchdog: divide 512, then 16
// - Sleep stops both oscillators
// - Option picks internal RC or external
// - Clock-signal option frees the output pin
// - Low oscillator stops only through sleep
// - Low clock feeds slow mode; watchdog runs on slow RC or instruction clock
// - Reset held until high oscillator starts
// - Sleep wake waits 2048 oscillator clocks
// - Green wake has no waiting time
// - Green wakes to prior mode; sleep normal
`timescale 1ns/1ps
module dual_clock_mode_control #(
	parameter int RC_START_EDGES = 16, // Start-up edges for RC types
	parameter int XTAL_START_EDGES = 8192 // Start-up edges for crystals
) (
	input wire logic clk_i, // 200 MHz system clock
	input wire logic rst_i, // Synchronous reset, active high
	// Classic Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Build options, static
	input wire logic internal_fast_rc_option_i,
	input wire logic ext_clock_signal_option_i,
	input wire logic xtal_high_option_i,
	input wire logic internal_slow_rc_option_i,
	// Oscillator clocks arriving as pins
	input wire logic osc_input_pin_i,
	input wire logic internal_fast_rc_i,
	input wire logic low_osc_input_pin_i,
	input wire logic internal_slow_rc_i,
	// Wake request from the wake pin logic, one level
	input wire logic wakeup_i,
	// Status and control outputs
	output logic high_osc_run_o,
	output logic low_osc_run_o,
	output logic slow_clock_o,
	output logic cpu_run_o,
	output logic instr_tick_o,
	output logic reset_hold_o,
	output logic watchdog_overflow_o,
	output logic osc_input_gpio_o,
	output logic osc_output_gpio_o
);
	import osc_mode_pkg::*;

	// Synchroniser stages and edge history for the four clocks
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] hist_q;
	logic [3:0] edge_w;

	// Control register and phase
	osc_ctrl_t ctrl_q, ctrl_d;
	phase_t phase_q, phase_d;
	logic [1:0] saved_mode_q, saved_mode_d; // Clock mode written together with the green entry
	logic [13:0] wait_q, wait_d; // Start-up and wake edge counter
	logic [3:0] div_q, div_d; // Instruction rate divider
	logic [13:0] pre_q, pre_d; // Watchdog prescaler
	logic [3:0] wd_q, wd_d; // Watchdog overflow counter
	logic [7:0] bus_byte_d;
	logic ack_d;
	logic high_osc_run_d, low_osc_run_d, slow_clock_d, cpu_run_d;
	logic instr_tick_d, reset_hold_d, watchdog_overflow_d;

	// Pin clocks pass two flops, then the edge history flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			hist_q <= 4'h0;
		end else begin
			sync1_q <= {internal_slow_rc_i, low_osc_input_pin_i, internal_fast_rc_i, osc_input_pin_i};
			sync2_q <= sync1_q;
			hist_q <= sync2_q;
		end
	end
	// Rising edges; oscillators must run well below half of clk_i
	assign edge_w = sync2_q & ~hist_q;

	// Prescale tap used more than once
	function automatic logic tap_done(input logic [13:0] cnt, input int bitpos);
		logic [13:0] mask;
		mask = (14'h0001 << bitpos) - 14'h0001;
		tap_done = ((cnt & mask) == mask);
	endfunction : tap_done

	// Next state of register, phase, dividers and watchdog
	always_comb begin
		logic high_edge;
		logic src_edge;
		logic [3:0] div_end;
		logic wr;
		logic rd_hit;
		logic wd_clr;
		logic wd_src;
		logic pre_tick;
		logic [13:0] start_edges;
		high_edge = 1'b0;
		src_edge = 1'b0;
		div_end = DIV_EXT_HIGH;
		wr = 1'b0;
		rd_hit = 1'b0;
		wd_clr = 1'b0;
		wd_src = 1'b0;
		pre_tick = 1'b0;
		start_edges = 14'(XTAL_START_EDGES - 1);
		ctrl_d = ctrl_q;
		phase_d = phase_q;
		saved_mode_d = saved_mode_q;
		wait_d = wait_q;
		div_d = div_q;
		pre_d = pre_q;
		wd_d = wd_q;
		bus_byte_d = 8'h00;
		ack_d = 1'b0;
		instr_tick_d = 1'b0;
		watchdog_overflow_d = 1'b0;

		// High clock source by build option
		high_edge = internal_fast_rc_option_i ? edge_w[1] : edge_w[0];
		if (!xtal_high_option_i || internal_fast_rc_option_i) begin
			start_edges = 14'(RC_START_EDGES - 1); // Short start for RC types
		end

		// Clear pulse from the previous write ends here
		ctrl_d.watchdog_clear = 1'b0;

		// Bus slave: one wait state, ack for one cycle
		if (cyc_i && stb_i && !ack_o) begin
			ack_d = 1'b1;
			rd_hit = (adr_i == OSC_CTRL_ADDR);
		end
		// Write lands on the edge where the master sees ack, never a cycle early
		wr = cyc_i && stb_i && ack_o && we_i && sel_i[0] && (adr_i == OSC_CTRL_ADDR);
		if (rd_hit) begin
			bus_byte_d = ctrl_q;
			bus_byte_d[WATCHDOG_CLOCK_POS] = ctrl_q.watchdog_clock_select | internal_slow_rc_option_i;
		end
		if (wr) begin
			ctrl_d = osc_ctrl_t'(dat_i[7:0]);
			ctrl_d.spare = 1'b0;
			wd_clr = dat_i[WATCHDOG_CLEAR_POS];
		end

		// Phase sequencing
		unique case (phase_q)
			PH_START: begin
				// Reset held until enough high clock edges
				if (high_edge) begin
					wait_d = wait_q + 14'h0001;
					if (wait_q == start_edges) begin
						phase_d = PH_RUN;
					end
				end
			end
			PH_RUN: begin
				if (wr && ctrl_d.cpu_operating_mode == MODE_SLEEP) begin
					phase_d = PH_SLEEP;
				end else if (wr && ctrl_d.cpu_operating_mode == MODE_GREEN) begin
					phase_d = PH_GREEN;
					saved_mode_d = {1'b0, ctrl_d.slow_clock_select};
				end
			end
			PH_SLEEP: begin
				if (wakeup_i) begin
					phase_d = PH_WAKE;
					wait_d = 14'h0000;
				end
			end
			PH_WAKE: begin
				// Oscillator settles before code resumes
				if (high_edge) begin
					wait_d = wait_q + 14'h0001;
					if (wait_q == 14'(WAKE_EDGES - 12'h001)) begin
						phase_d = PH_RUN;
						ctrl_d.cpu_operating_mode = MODE_NORMAL;
						ctrl_d.slow_clock_select = 1'b0;
					end
				end
			end
			PH_GREEN: begin
				// Clocks never stopped, so resume at once
				if (wakeup_i) begin
					phase_d = PH_RUN;
					ctrl_d.cpu_operating_mode = MODE_NORMAL;
					ctrl_d.slow_clock_select = saved_mode_q[0];
				end
			end
			default: begin
				phase_d = PH_START;
			end
		endcase

		// Instruction rate from the selected system clock
		if (ctrl_q.slow_clock_select) begin
			src_edge = edge_w[2];
			div_end = DIV_LOW;
		end else begin
			src_edge = high_edge;
			div_end = internal_fast_rc_option_i ? DIV_INT_HIGH : DIV_EXT_HIGH;
		end
		if (phase_q == PH_RUN || phase_q == PH_GREEN) begin
			if (src_edge) begin
				if (div_q >= div_end) begin
					div_d = 4'h0;
					instr_tick_d = 1'b1;
				end else begin
					div_d = div_q + 4'h1;
				end
			end
		end else begin
			div_d = 4'h0;
		end

		// Watchdog clock source and prescale
		if (ctrl_q.watchdog_clock_select || internal_slow_rc_option_i) begin
			wd_src = edge_w[3];
			pre_tick = wd_src && tap_done(pre_q, SLOW_RC_DIV_BIT + 1); // 512 edges
		end else begin
			wd_src = instr_tick_o;
			pre_tick = wd_src && (ctrl_q.watchdog_prescale_select ?
				tap_done(pre_q, PRESCALE_SHORT_BIT + 1) : tap_done(pre_q, PRESCALE_LONG_BIT + 1));
		end
		if (wd_src) begin
			pre_d = pre_tick ? PRESCALE_RESET : pre_q + 14'h0001;
		end
		if (pre_tick) begin
			wd_d = wd_q + 4'h1;
			watchdog_overflow_d = (wd_q == 4'hF); // Sixteen prescale ticks
		end
		// Software clear wins over a counting tick
		if (wd_clr) begin
			pre_d = PRESCALE_RESET;
			wd_d = WD_COUNT_RESET;
			watchdog_overflow_d = 1'b0;
		end

		// Registered outputs
		reset_hold_d = (phase_d == PH_START);
		cpu_run_d = (phase_d == PH_RUN);
		slow_clock_d = ctrl_d.slow_clock_select;
		// Sleep stops both; stop bit only the high one
		high_osc_run_d = (phase_d != PH_SLEEP) && !(ctrl_d.high_osc_stop && phase_d != PH_WAKE);
		low_osc_run_d = (phase_d != PH_SLEEP); // No other stop path
	end

	// Register everything computed above
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= osc_ctrl_t'(OSC_CTRL_RESET);
			phase_q <= PH_START;
			saved_mode_q <= MODE_NORMAL;
			wait_q <= 14'h0000;
			div_q <= 4'h0;
			pre_q <= PRESCALE_RESET;
			wd_q <= WD_COUNT_RESET;
			dat_o <= 32'h0000_0000;
			ack_o <= 1'b0;
			high_osc_run_o <= 1'b1;
			low_osc_run_o <= 1'b1;
			slow_clock_o <= 1'b0;
			cpu_run_o <= 1'b0;
			instr_tick_o <= 1'b0;
			reset_hold_o <= 1'b1;
			watchdog_overflow_o <= 1'b0;
			osc_input_gpio_o <= 1'b0;
			osc_output_gpio_o <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			phase_q <= phase_d;
			saved_mode_q <= saved_mode_d;
			wait_q <= wait_d;
			div_q <= div_d;
			pre_q <= pre_d;
			wd_q <= wd_d;
			dat_o <= {24'h00_0000, bus_byte_d};
			ack_o <= ack_d;
			high_osc_run_o <= high_osc_run_d;
			low_osc_run_o <= low_osc_run_d;
			slow_clock_o <= slow_clock_d;
			cpu_run_o <= cpu_run_d;
			instr_tick_o <= instr_tick_d;
			reset_hold_o <= reset_hold_d;
			watchdog_overflow_o <= watchdog_overflow_d;
			// Oscillator pins freed for general I/O by option
			osc_input_gpio_o <= internal_fast_rc_option_i;
			osc_output_gpio_o <= internal_fast_rc_option_i | ext_clock_signal_option_i;
		end
	end
endmodule : dual_clock_mode_control

// file: verif/dual_clock_mode_control_chk.sv
// Port checker for the dual clock mode controller
`timescale 1ns/1ps
module dual_clock_mode_control_chk
	import osc_mode_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic high_osc_run_o,
	input wire logic low_osc_run_o,
	input wire logic slow_clock_o,
	input wire logic cpu_run_o,
	input wire logic instr_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Control byte write accepted while the CPU runs
	sequence s_wr;
		ack_o && we_i && cyc_i && stb_i && adr_i == OSC_CTRL_ADDR && sel_i[0] && cpu_run_o;
	endsequence
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack1; ack_o |=> !ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_bit0; ack_o && !we_i |-> dat_o[0] == 1'b0; endproperty
	a_bit0: assert property (p_bit0) else $error("bit 0 set");
	property p_sleep; s_wr ##0 dat_i[4:3] == MODE_SLEEP |-> ##2 !high_osc_run_o && !low_osc_run_o; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep keeps osc");
	property p_green; s_wr ##0 dat_i[4:3] == MODE_GREEN |-> ##2 !cpu_run_o && low_osc_run_o; endproperty
	a_green: assert property (p_green) else $error("green wrong");
	property p_stop; s_wr ##0 dat_i[4:1] == 4'h3 |-> ##2 !high_osc_run_o && low_osc_run_o && slow_clock_o; endproperty
	a_stop: assert property (p_stop) else $error("stop wrong");
	property p_norm; s_wr ##0 dat_i[4:1] == 4'h0 |-> ##2 !slow_clock_o && high_osc_run_o; endproperty
	a_norm: assert property (p_norm) else $error("normal wrong");
	property p_tick; instr_tick_o |=> !instr_tick_o [*8]; endproperty
	a_tick: assert property (p_tick) else $error("ticks too close");
	property p_quiet; !low_osc_run_o [*2] |-> !instr_tick_o; endproperty
	a_quiet: assert property (p_quiet) else $error("tick in sleep");
endmodule : dual_clock_mode_control_chk
bind dual_clock_mode_control dual_clock_mode_control_chk dual_clock_mode_control_chk_i (.*);

// file: verif/osc_src.sv
// Oscillator sources beside the clock mode controller
`timescale 1ns/1ps
module osc_src (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hi_en_i,
	input wire logic lo_en_i,
	output logic hi_o,
	output logic lo_o,
	output logic rc_o
);
	logic [2:0] hc_q, hc_d, lc_q, lc_d; // Half period counters
	logic [2:0] lv_d; // Next rc, lo, hi levels
	// Disabled sources park low, a stopped oscillator gives no edges
	always_comb begin
		hc_d = (hc_q == 3'h2) ? 3'h0 : hc_q + 3'h1;
		lc_d = (lc_q == 3'h3) ? 3'h0 : lc_q + 3'h1;
		lv_d[0] = hi_en_i & (hi_o ^ (hc_q == 3'h2));
		lv_d[1] = lo_en_i & (lo_o ^ (lc_q == 3'h3));
		lv_d[2] = rc_o ^ (lc_q == 3'h3);
	end
	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{hc_q, lc_q} <= 6'h00;
			{rc_o, lo_o, hi_o} <= 3'h0;
		end else begin
			{hc_q, lc_q} <= {hc_d, lc_d};
			{rc_o, lo_o, hi_o} <= lv_d;
		end
	end
endmodule : osc_src

// file: verif/tb_dual_clock_mode_control.sv
// Self-checking bench for the dual clock mode controller
`timescale 1ns/1ps
module tb_dual_clock_mode_control;
	import osc_mode_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, wakeup_i = 1'b0;
	logic [11:0] adr_i = 12'h000;
	logic [3:0] sel_i = 4'hF; // Byte lane always on
	logic [31:0] dat_i = 32'h0000_0000, dat_o, r;
	logic [3:0] opt = 4'h0; // Fast rc, clock signal, crystal, slow rc
	logic ack_o, high_osc_run_o, low_osc_run_o, slow_clock_o, cpu_run_o, instr_tick_o, hi, lo, rc;
	logic reset_hold_o, watchdog_overflow_o, osc_input_gpio_o, osc_output_gpio_o;
	int n_fail = 0, compares = 0, ticks = 0;
	// Crystal start-up cut short to keep the run brief
	dual_clock_mode_control #(.XTAL_START_EDGES(32)) dual_clock_mode_control_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.internal_fast_rc_option_i(opt[3]), .ext_clock_signal_option_i(opt[2]), .xtal_high_option_i(opt[1]),
		.internal_slow_rc_option_i(opt[0]), .osc_input_pin_i(hi), .internal_fast_rc_i(hi),
		.low_osc_input_pin_i(lo), .internal_slow_rc_i(rc), .wakeup_i(wakeup_i),
		.high_osc_run_o(high_osc_run_o), .low_osc_run_o(low_osc_run_o), .slow_clock_o(slow_clock_o),
		.cpu_run_o(cpu_run_o), .instr_tick_o(instr_tick_o), .reset_hold_o(reset_hold_o),
		.watchdog_overflow_o(watchdog_overflow_o), .osc_input_gpio_o(osc_input_gpio_o),
		.osc_output_gpio_o(osc_output_gpio_o));
	osc_src osc_src_i (.clk_i(clk_i), .rst_i(rst_i), .hi_en_i(high_osc_run_o), .lo_en_i(low_osc_run_o),
		.hi_o(hi), .lo_o(lo), .rc_o(rc));
	always #2.5 clk_i = ~clk_i;
	// Hang guard, above the sleep wake wait plus the slow rc watchdog run
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 90000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic flag(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : flag
	// Classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] d, input logic [11:0] a = OSC_CTRL_ADDR);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h00_0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (w)
			repeat (2) @(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [7:0] e, input logic [11:0] a = OSC_CTRL_ADDR);
		wb(1'b0, 8'h00, a);
		chk(r, {24'h00_0000, e});
	endtask : rd
	// Cycles between two instruction ticks
	task automatic gap(input logic [31:0] e);
		int t;
		t = 0;
		repeat (40) @(posedge clk_i);
		do @(posedge clk_i); while (instr_tick_o !== 1'b1);
		do begin
			@(posedge clk_i);
			t++;
		end while (instr_tick_o !== 1'b1);
		chk(t, e);
	endtask : gap
	task automatic boot(input logic [3:0] o);
		rst_i <= 1'b1;
		opt <= o;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		do @(posedge clk_i); while (reset_hold_o !== 1'b0);
		flag(cpu_run_o, 1'b1);
	endtask : boot
	task automatic wake(output int t);
		t = 0;
		wakeup_i <= 1'b1;
		do begin
			@(posedge clk_i);
			t++;
		end while (cpu_run_o !== 1'b1);
		wakeup_i <= 1'b0;
	endtask : wake
	task automatic t_reg();
		boot(4'h0);
		rd(OSC_CTRL_RESET);
		rd(8'h00, 12'h000);
		gap(32'h18);
		wb(1'b1, 8'hE7);
		flag(low_osc_run_o, 1'b1);
		flag(high_osc_run_o, 1'b0);
		rd(8'hA6);
		gap(32'h20);
		wb(1'b1, 8'h18);
		rd(8'h18);
		wb(1'b1, 8'h00);
		$display("register test done");
	endtask : t_reg
	task automatic t_modes();
		int t;
		wb(1'b1, 8'h08);
		flag(high_osc_run_o | low_osc_run_o, 1'b0);
		wake(t);
		flag(t > 12270 && t < 12340, 1'b1);
		rd(8'h00);
		wb(1'b1, 8'h14);
		wake(t);
		flag(t < 4, 1'b1);
		rd(8'h04);
		wb(1'b1, 8'h00);
		$display("mode test done");
	endtask : t_modes
	task automatic t_opts();
		int t;
		boot(4'h9);
		gap(32'h60);
		flag(osc_input_gpio_o & osc_output_gpio_o, 1'b1);
		rd(8'h80);
		// Clear, then 512 x 16 slow rc edges of 8 cycles each until overflow
		wb(1'b1, 8'h40);
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (watchdog_overflow_o !== 1'b1);
		flag(t > 65520 && t < 65545, 1'b1);
		@(posedge clk_i);
		flag(watchdog_overflow_o, 1'b0);
		boot(4'h4);
		flag(osc_input_gpio_o, 1'b0);
		flag(osc_output_gpio_o, 1'b1);
		boot(4'h2);
		$display("option test done");
	endtask : t_opts
	initial begin
		t_reg();
		t_modes();
		t_opts();
		final_report();
	end
endmodule : tb_dual_clock_mode_control
